// file: rtl/bmc_top.sv
// battery monitor and charge control sequencer
// assumes pins are asynchronous; all but i_nrst and i_shutdown_done pass a two-stage synchroniser
//
// Notes on behaviour
// [R1] charge control disabled: main normal charge while adaptor is present
// [R2] aux trickle path on while last reading is at or below 5.0V
// [R3] on low detect hold aux charge mode low for 8 hours, then release
// [R4] adaptor detect high starts main charge timing from the ms tick
// [R5] battery supply moves to aux battery at 4.7V or below
// [R6] converter power output high powers converter and divider
// [R7] low voltage declared when code is at or below d9
// [R8] detect in power on and off; drop converter power on low detect
// [R9] power off: one 8 ms window every 10 seconds
// [R10] chip select asserted 4 ms after converter power applied
// [R11] converter shifts the selected channel result out serially
// [R12] after low detect battery select output goes high
// [R13] power on output low while on; aux gate follows battery select
// [R14] power off blocks aux to main supply, backup line stays on
// [R15] battery select high enables aux backup feed
// [R16] after shutdown following low detect raise recharge message
// [R17] power on keeps aux charged from display supply
// [R18] adaptor connect: normal charge 11 h on or 8 h off, then trickle
// [R19] trickle with adaptor returns to normal at 5.0V or below
// [R20] threshold compared only on a full reading inside the window
`timescale 1ns/1ps
module bmc_top #(
    parameter int P_TICK_CYC = bmc_pkg::TICK_CYC,
    parameter int P_PERIOD_MS = bmc_pkg::OFF_PERIOD_S * bmc_pkg::MS_PER_S,
    parameter int P_AUX_MS = bmc_pkg::AUX_NORM_H * bmc_pkg::MS_PER_H,
    parameter int P_MAIN_ON_MS = bmc_pkg::MAIN_ON_H * bmc_pkg::MS_PER_H,
    parameter int P_MAIN_OFF_MS = bmc_pkg::MAIN_OFF_H * bmc_pkg::MS_PER_H
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_power_sw,
    input wire logic i_adaptor_detect_in,
    input wire logic i_charge_ctl_dis,
    input wire logic i_aux_charge_jumper,
    input wire logic i_adc_so,
    input wire logic i_shutdown_done,
    output logic o_adc_power,
    output logic o_adc_cs_n,
    output logic o_adc_sclk,
    output logic o_power_on_n_out,
    output logic o_battery_select_out,
    output logic o_aux_main_gate_en,
    output logic o_backup_feed_en,
    output logic o_backup_line_en,
    output logic o_main_charge_mode_out,
    output logic o_aux_charge_mode_out,
    output logic o_aux_trickle_en,
    output logic o_aux_lcd_charge_en,
    output logic o_recharge_msg
);
    import bmc_pkg::*;

    bmc_adc_if adc ();
    bmc_adc_rd u_rd (.i_mclk(i_mclk), .i_nrst(i_nrst), .adc(adc));

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NPIN-1:0] pin_raw, meta_q, pin_s;
    assign pin_raw = {i_adc_so, i_aux_charge_jumper, i_charge_ctl_dis,
        i_adaptor_detect_in, i_power_sw};
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        always_ff @(posedge i_mclk or negedge i_nrst) begin
            if (!i_nrst) begin
                meta_q[g] <= 1'b0;
                pin_s[g] <= 1'b0;
            end else begin
                meta_q[g] <= pin_raw[g];
                pin_s[g] <= meta_q[g];
            end
        end
    end
    logic pwr, adp, dis, jmp;
    assign pwr = pin_s[PIN_PWR];
    assign adp = pin_s[PIN_ADP];
    assign dis = pin_s[PIN_DIS];
    assign jmp = pin_s[PIN_JMP];
    assign adc.so = pin_s[PIN_SO];

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [14:0] tk_q, tk_d;
    logic tick, tick_clr;
    assign tick = (tk_q == 15'(P_TICK_CYC - 1));
    always_comb begin
        tk_d = (tick || tick_clr) ? 15'h0000 : 15'(tk_q + 15'h0001);
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tk_q <= 15'h0000;
        end else begin
            tk_q <= tk_d;
        end
    end

    // ------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------
    bmc_meas_t ms_q, ms_d;
    logic [13:0] per_q, per_d, lim;
    logic [3:0] win_q, win_d;
    logic apwr_q, apwr_d, start_q, start_d, low_q, low_d, le5_q, le5_d;
    logic rd_ok, rd_le5;
    // after a low detect only keep sampling while charge can recover
    assign lim = pwr ? ON_LIM : 14'(P_PERIOD_MS - 1);
    assign rd_ok = adc.done && (ms_q == MS_CONV); // [R20]
    assign rd_le5 = rd_ok && (adc.code <= CHG5V_CODE);
    always_comb begin
        ms_d = ms_q;
        per_d = per_q;
        win_d = win_q;
        apwr_d = apwr_q;
        start_d = 1'b0;
        low_d = low_q;
        le5_d = le5_q;
        tick_clr = 1'b0;
        if (tick && per_q < lim) begin
            per_d = 14'(per_q + 14'h0001);
        end
        if (tick && ms_q != MS_IDLE) begin
            win_d = 4'(win_q + 4'h1);
        end
        case (ms_q)
            MS_IDLE: begin
                if (tick && per_q >= lim && (!low_q || adp)) begin // [R8]
                    ms_d = MS_SETTLE;
                    apwr_d = 1'b1; // [R6] [R9]
                    per_d = 14'h0000;
                    win_d = 4'h0;
                    tick_clr = 1'b1;
                end
            end
            MS_SETTLE: begin
                if (tick && win_q == CS_M1) begin
                    ms_d = MS_CONV;
                    start_d = 1'b1; // [R10]
                end
            end
            MS_CONV: begin
                if (rd_ok) begin
                    le5_d = (adc.code <= CHG5V_CODE);
                    ms_d = MS_HOLD;
                    if (adc.code <= LOW_CODE) begin // [R7] [R5]
                        low_d = 1'b1;
                        apwr_d = 1'b0; // [R8]
                        ms_d = MS_IDLE;
                    end
                end else if (tick && win_q == WIN_M1) begin
                    // late result is discarded, not compared
                    apwr_d = 1'b0;
                    ms_d = MS_IDLE;
                end
            end
            MS_HOLD: begin
                if (tick && win_q == WIN_M1) begin
                    apwr_d = 1'b0; // [R9]
                    ms_d = MS_IDLE;
                end
            end
            default: ms_d = MS_IDLE;
        endcase
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ms_q <= MS_IDLE;
            per_q <= 14'h0000;
            win_q <= 4'h0;
            apwr_q <= 1'b0;
            start_q <= 1'b0;
            low_q <= 1'b0;
            le5_q <= 1'b0;
        end else begin
            ms_q <= ms_d;
            per_q <= per_d;
            win_q <= win_d;
            apwr_q <= apwr_d;
            start_q <= start_d;
            low_q <= low_d;
            le5_q <= le5_d;
        end
    end
    assign adc.start = start_q;

    // ------------------------------------------------------------
    // aux and main charge timers
    // ------------------------------------------------------------
    logic [24:0] aux_q, aux_d;
    logic [25:0] mt_q, mt_d;
    logic auxp_q, auxp_d, trk_q, trk_d, adp_q;
    always_comb begin
        aux_d = aux_q;
        auxp_d = auxp_q;
        if (low_d && !low_q) begin
            aux_d = 25'(P_AUX_MS);
            auxp_d = 1'b0; // [R3]
        end else if (!auxp_q && tick) begin
            if (aux_q <= 25'h0000001) begin
                auxp_d = 1'b1;
            end
            aux_d = 25'(aux_q - 25'h0000001);
        end
    end
    always_comb begin
        mt_d = mt_q;
        trk_d = trk_q;
        if (!adp) begin
            trk_d = 1'b1;
            mt_d = 26'h0000000;
        end else if (dis) begin
            trk_d = 1'b0; // [R1]
        end else if ((adp && !adp_q) || (trk_q && rd_le5)) begin
            trk_d = 1'b0; // [R4] [R18] [R19]
            mt_d = pwr ? 26'(P_MAIN_ON_MS) : 26'(P_MAIN_OFF_MS);
        end else if (!trk_q && tick) begin
            if (mt_q <= 26'h0000001) begin
                trk_d = 1'b1; // [R18]
            end
            mt_d = (mt_q == 26'h0000000) ? mt_q : 26'(mt_q - 26'h0000001);
        end
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            aux_q <= 25'h0000000;
            auxp_q <= 1'b1;
            mt_q <= 26'h0000000;
            trk_q <= 1'b1;
            adp_q <= 1'b0;
        end else begin
            aux_q <= aux_d;
            auxp_q <= auxp_d;
            mt_q <= mt_d;
            trk_q <= trk_d;
            adp_q <= adp;
        end
    end

    // ------------------------------------------------------------
    // supply gating and status outputs
    // ------------------------------------------------------------
    logic pon_n_q, gate_q, feed_q, trkl_q, lcd_q, msg_q;
    logic pon_n_d, gate_d, feed_d, trkl_d, lcd_d, msg_d;
    always_comb begin
        pon_n_d = !pwr; // [R13]
        gate_d = pwr && low_q && jmp; // [R13] [R14]
        feed_d = low_q && jmp; // [R15]
        trkl_d = le5_q && jmp; // [R2]
        lcd_d = pwr && jmp; // [R17]
        msg_d = msg_q || (low_q && i_shutdown_done); // [R16]
    end
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pon_n_q <= 1'b1;
            gate_q <= 1'b0;
            feed_q <= 1'b0;
            trkl_q <= 1'b0;
            lcd_q <= 1'b0;
            msg_q <= 1'b0;
        end else begin
            pon_n_q <= pon_n_d;
            gate_q <= gate_d;
            feed_q <= feed_d;
            trkl_q <= trkl_d;
            lcd_q <= lcd_d;
            msg_q <= msg_d;
        end
    end

    assign o_adc_power = apwr_q;
    assign o_adc_cs_n = adc.cs_n;
    assign o_adc_sclk = adc.sclk;
    assign o_power_on_n_out = pon_n_q;
    assign o_battery_select_out = low_q; // [R12]
    assign o_aux_main_gate_en = gate_q;
    assign o_backup_feed_en = feed_q;
    assign o_backup_line_en = i_nrst; // [R14]
    assign o_main_charge_mode_out = trk_q;
    assign o_aux_charge_mode_out = auxp_q;
    assign o_aux_trickle_en = trkl_q;
    assign o_aux_lcd_charge_en = lcd_q;
    assign o_recharge_msg = msg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    int pw_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pw_q <= 0;
        end else begin
            pw_q <= apwr_q ? pw_q + 1 : 0;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    cs_delay_a: assert property ($fell(o_adc_cs_n) |-> // [R10]
        pw_q == CS_DELAY_MS * P_TICK_CYC + 1)
        else $error("chip select not 4 ms after power");
    win_len_a: assert property ($fell(o_adc_power) |-> // [R9]
        pw_q == WIN_MS * P_TICK_CYC || o_battery_select_out)
        else $error("window length wrong");
    cs_pwr_a: assert property (!o_adc_cs_n |-> o_adc_power) // [R6]
        else $error("chip select without converter power");
    low_cut_a: assert property (rd_ok && adc.code <= LOW_CODE |=> // [R8]
        !o_adc_power && o_battery_select_out)
        else $error("power not cut on low detect");
    low_cause_a: assert property ($rose(o_battery_select_out) |-> // [R7]
        $past(rd_ok) && $past(adc.code) <= LOW_CODE)
        else $error("low declared without low code");
    aux_hold_a: assert property ($rose(o_battery_select_out) |-> // [R3]
        !o_aux_charge_mode_out ##1 !o_aux_charge_mode_out)
        else $error("aux charge mode not forced low");
    gate_off_a: assert property (o_power_on_n_out |-> // [R14]
        !o_aux_main_gate_en)
        else $error("aux gated while power off");
    gate_on_a: assert property ($past(low_q && jmp && pwr) |-> // [R13]
        o_aux_main_gate_en && !o_power_on_n_out)
        else $error("aux gate missing while on");
    dis_chg_a: assert property ($past(adp && dis) |-> // [R1]
        !o_main_charge_mode_out)
        else $error("normal charge dropped with control off");
    chg_start_a: assert property ($rose(adp) && !dis |=> // [R18]
        !o_main_charge_mode_out)
        else $error("adaptor connect did not start charge");
    lcd_chg_a: assert property ($past(pwr && jmp) |-> // [R17]
        o_aux_lcd_charge_en)
        else $error("aux not charged while on");

    low_seen_c: cover property (rd_ok && adc.code <= LOW_CODE);
    full_win_c: cover property (rd_ok ##[1:300] $fell(o_adc_power));
    trk_back_c: cover property (trk_q && rd_le5 ##1 !trk_q);
endmodule

// file: rtl/bmc_pkg.sv
// battery monitor and charge control: shared constants and types
// assumes a single 20 MHz clock and an 8-bit serial converter
package bmc_pkg;
    // ------------------------------------------------------------
    // clock and derived rates
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int SCLK_HALF_NS = 1000;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam logic [4:0] SCLK_HALF_M1 = 5'(SCLK_HALF_CYC - 1);
    // ------------------------------------------------------------
    // sampling and charge times
    // ------------------------------------------------------------
    localparam int MS_PER_S = 1000;
    localparam int MS_PER_H = 3_600_000;
    localparam int WIN_MS = 8;
    localparam int CS_DELAY_MS = 4;
    localparam int OFF_PERIOD_S = 10;
    localparam int ON_PERIOD_MS = 100;
    localparam int AUX_NORM_H = 8;
    localparam int MAIN_ON_H = 11;
    localparam int MAIN_OFF_H = 8;
    localparam logic [3:0] WIN_M1 = 4'(WIN_MS - 1);
    localparam logic [3:0] CS_M1 = 4'(CS_DELAY_MS - 1);
    localparam logic [13:0] ON_LIM = 14'(ON_PERIOD_MS - 1);
    // ------------------------------------------------------------
    // converter codes and pin slots
    // ------------------------------------------------------------
    localparam int CODE_W = 8;
    localparam logic [7:0] LOW_CODE = 8'hd9;
    localparam logic [7:0] CHG5V_CODE = 8'he6;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int NPIN = 5;
    localparam int PIN_PWR = 0;
    localparam int PIN_ADP = 1;
    localparam int PIN_DIS = 2;
    localparam int PIN_JMP = 3;
    localparam int PIN_SO = 4;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_SETTLE = 2'b01,
        MS_CONV = 2'b10,
        MS_HOLD = 2'b11
    } bmc_meas_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_LEAD = 2'b01,
        RD_HIGH = 2'b10,
        RD_LOW = 2'b11
    } bmc_rd_t;
endpackage

// file: rtl/bmc_adc_if.sv
// link between the sequencer and the serial converter reader
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface bmc_adc_if;
    logic start;
    logic so;
    logic cs_n;
    logic sclk;
    logic done;
    logic [7:0] code;
    modport ctl (output start, output so, input cs_n, input sclk,
        input done, input code);
    modport rd (input start, input so, output cs_n, output sclk,
        output done, output code);
endinterface

// file: rtl/bmc_adc_rd.sv
// serial converter reader: chip select, bit clock, 8-bit shift in
// assumes so is already synchronised by the caller
`timescale 1ns/1ps
module bmc_adc_rd (
    input wire logic i_mclk,
    input wire logic i_nrst,
    bmc_adc_if.rd adc
);
    import bmc_pkg::*;

    bmc_rd_t st_q, st_d;
    logic [4:0] div_q, div_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, code_q, code_d;
    logic cs_n_q, cs_n_d, sclk_q, sclk_d, done_q, done_d;
    logic half_end;

    // ------------------------------------------------------------
    // shift sequence
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        div_d = div_q;
        bit_d = bit_q;
        sh_d = sh_q;
        code_d = code_q;
        cs_n_d = cs_n_q;
        sclk_d = sclk_q;
        done_d = 1'b0;
        half_end = (div_q == SCLK_HALF_M1);
        if (st_q != RD_IDLE) begin
            div_d = half_end ? 5'h00 : 5'(div_q + 5'h01);
        end
        case (st_q)
            RD_IDLE: begin
                if (adc.start) begin
                    st_d = RD_LEAD;
                    cs_n_d = 1'b0;
                    div_d = 5'h00;
                    bit_d = 3'h0;
                end
            end
            RD_LEAD: begin
                if (half_end) begin
                    st_d = RD_HIGH;
                    sclk_d = 1'b1;
                end
            end
            RD_HIGH: begin
                // sample late in the high half, data long settled
                if (half_end) begin
                    sh_d = {sh_q[6:0], adc.so}; // [R11]
                    sclk_d = 1'b0;
                    st_d = RD_LOW;
                end
            end
            RD_LOW: begin
                if (half_end) begin
                    if (bit_q == LAST_BIT) begin
                        st_d = RD_IDLE;
                        cs_n_d = 1'b1;
                        done_d = 1'b1;
                        code_d = sh_q;
                    end else begin
                        bit_d = 3'(bit_q + 3'h1);
                        sclk_d = 1'b1;
                        st_d = RD_HIGH;
                    end
                end
            end
            default: st_d = RD_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= RD_IDLE;
            div_q <= 5'h00;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            code_q <= 8'h00;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            code_q <= code_d;
            cs_n_q <= cs_n_d;
            sclk_q <= sclk_d;
            done_q <= done_d;
        end
    end

    assign adc.cs_n = cs_n_q;
    assign adc.sclk = sclk_q;
    assign adc.done = done_q;
    assign adc.code = code_q;
endmodule

// file: test/bmc_adc_model.sv
// converter model: 8-bit result shifted out msb first on chip select
// assumes sclk idles low and the reader samples while sclk is high
`timescale 1ns/1ps
module bmc_adc_model (
    input wire logic i_mclk,
    input wire logic i_pwr,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic [7:0] i_code,
    output logic o_so
);
    logic [7:0] sh_q;
    logic sel_q;
    logic sclk_q;
    initial begin
        sh_q = 8'h00;
        sel_q = 1'b0;
        sclk_q = 1'b0;
        o_so = 1'b0;
    end
    // ----------------------------------------
    // shift out
    // ----------------------------------------
    always @(posedge i_mclk) begin
        sclk_q <= i_sclk;
        if (!i_pwr || i_cs_n) begin
            // released line toggles, so a stale bit never reads as good
            sel_q <= 1'b0;
            o_so <= ~o_so;
        end else if (!sel_q) begin
            sel_q <= 1'b1;
            sh_q <= {i_code[6:0], 1'b0};
            o_so <= i_code[7];
        end else if (sclk_q && !i_sclk) begin
            sh_q <= {sh_q[6:0], 1'b0};
            o_so <= sh_q[7];
        end
    end
endmodule

// file: test/bmc_top_bench.sv
// bench for the battery monitor: reading table, then timer tests
// assumes the converter model on the far side of the serial pins
`timescale 1ns/1ps
module bmc_top_bench;
    import bmc_pkg::*;
    // short tick keeps the run small; all timer figures scale from it, the conversion time does not
    localparam int T = 100;
    typedef struct {
        logic [7:0] code;
        logic pwr;
        logic low;
        logic trk;
    } bmc_row_t;
    logic i_mclk, i_nrst, i_power_sw, i_adaptor_detect_in;
    logic i_charge_ctl_dis, i_aux_charge_jumper, i_adc_so, i_shutdown_done;
    logic o_adc_power, o_adc_cs_n, o_adc_sclk, o_power_on_n_out;
    logic o_battery_select_out, o_aux_main_gate_en, o_backup_feed_en;
    logic o_backup_line_en, o_main_charge_mode_out, o_aux_charge_mode_out;
    logic o_aux_trickle_en, o_aux_lcd_charge_en, o_recharge_msg;
    logic [7:0] code;
    int err_count, comparisons, a, b, n;
    bmc_row_t rows [5] = '{'{8'hd9, 1'b0, 1'b1, 1'b1},
        '{8'hda, 1'b0, 1'b0, 1'b1}, '{8'he6, 1'b0, 1'b0, 1'b1},
        '{8'he7, 1'b0, 1'b0, 1'b0}, '{8'h00, 1'b1, 1'b1, 1'b1}};
    bmc_top #(.P_TICK_CYC(T), .P_PERIOD_MS(20), .P_AUX_MS(50),
        .P_MAIN_ON_MS(60), .P_MAIN_OFF_MS(40)) DUT (
        .i_mclk, .i_nrst, .i_power_sw, .i_adaptor_detect_in,
        .i_charge_ctl_dis, .i_aux_charge_jumper, .i_adc_so,
        .i_shutdown_done, .o_adc_power, .o_adc_cs_n, .o_adc_sclk,
        .o_power_on_n_out, .o_battery_select_out, .o_aux_main_gate_en,
        .o_backup_feed_en, .o_backup_line_en, .o_main_charge_mode_out,
        .o_aux_charge_mode_out, .o_aux_trickle_en, .o_aux_lcd_charge_en,
        .o_recharge_msg);
    bmc_adc_model adc (.i_mclk, .i_pwr(o_adc_power), .i_cs_n(o_adc_cs_n),
        .i_sclk(o_adc_sclk), .i_code(code), .o_so(i_adc_so));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick;
        @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("errors %0d compares %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rst(input logic pwr);
        i_nrst = 1'b0;
        i_power_sw = pwr;
        i_adaptor_detect_in = 1'b0;
        i_charge_ctl_dis = 1'b0;
        i_shutdown_done = 1'b0;
        code = 8'hff;
        repeat (12) tick;
        chk({o_adc_power, o_adc_cs_n, o_adc_sclk, o_power_on_n_out,
            o_battery_select_out, o_main_charge_mode_out,
            o_aux_charge_mode_out, o_backup_line_en}, 8'h56);
        i_nrst = 1'b1;
        tick;
        chk(o_backup_line_en, 1'b1);
        repeat (4) tick;
    endtask
    // counts from converter power rise to chip select and to power drop
    task automatic win(output int ncs, output int nend);
        int k;
        k = 0;
        ncs = 0;
        while (o_adc_power !== 1'b1 && k < 12000) begin
            tick;
            k++;
        end
        k = 0;
        while (o_adc_power === 1'b1 && k < 900) begin
            tick;
            k++;
            if (o_adc_cs_n === 1'b0 && ncs == 0) begin
                ncs = k;
            end
        end
        nend = k;
    endtask
    task automatic wait_lvl(input int lim, input logic v);
        n = 0;
        while (o_main_charge_mode_out !== v && n < lim) begin
            tick;
            n++;
        end
    endtask
    // ----------------------------------------
    // run
    // ----------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        // the full sequence takes roughly 60k cycles
        repeat (90000) @(posedge i_mclk);
        err_count++;
        results;
    end
    initial begin
        err_count = 0;
        comparisons = 0;
        i_aux_charge_jumper = 1'b1;
        rst(1'b0);
        foreach (rows[i]) begin
            rst(rows[i].pwr);
            code = rows[i].code;
            win(a, b);
            repeat (3) tick;
            chk(a, 4 * T + 1);
            chk(b < 8 * T, rows[i].low);
            chk(b > 4 * T + 341, 1'b1);
            chk(o_battery_select_out, rows[i].low);
            chk(o_aux_charge_mode_out, !rows[i].low);
            chk(o_backup_feed_en, rows[i].low);
            chk(o_aux_main_gate_en, rows[i].low & rows[i].pwr);
            chk(o_aux_trickle_en, rows[i].trk);
            chk(o_power_on_n_out, !rows[i].pwr);
            chk(o_aux_lcd_charge_en, rows[i].pwr);
            if (rows[i].low) begin
                n = 0;
                repeat (2500) begin
                    tick;
                    n = n + int'(o_adc_power === 1'b1);
                end
                chk(n, 0);
            end
        end
        // window spacing, then low detect with aux timer and message
        rst(1'b0);
        i_shutdown_done = 1'b1;
        win(a, b);
        n = b;
        while (o_adc_power !== 1'b1 && n < 3000) begin
            tick;
            n++;
        end
        chk(n, 20 * T);
        chk(o_recharge_msg, 1'b0);
        code = 8'hd9;
        win(a, b);
        repeat (2) tick;
        chk(o_recharge_msg, 1'b1);
        n = 0;
        while (o_aux_charge_mode_out === 1'b0 && n < 9000) begin
            tick;
            n++;
        end
        chk(n >= 48 * T && n <= 50 * T + 1, 1'b1);
        // main normal charge length, power off then on
        for (int p = 0; p < 2; p++) begin
            rst(p[0]);
            i_adaptor_detect_in = 1'b1;
            wait_lvl(20, 1'b0);
            chk(o_main_charge_mode_out, 1'b0);
            wait_lvl(9000, 1'b1);
            chk(n >= (p ? 59 : 39) * T && n <= (p ? 60 : 40) * T + 1,
                1'b1);
        end
        // trickle back to normal on a low reading
        code = 8'he6;
        wait_lvl(12000, 1'b0);
        chk(o_main_charge_mode_out, 1'b0);
        code = 8'hff;
        i_charge_ctl_dis = 1'b1;
        repeat (7000) tick;
        chk(o_main_charge_mode_out, 1'b0);
        i_adaptor_detect_in = 1'b0;
        repeat (5) tick;
        chk(o_main_charge_mode_out, 1'b1);
        // open jumper: aux charge paths must drop while still powered on
        i_aux_charge_jumper = 1'b0;
        repeat (5) tick;
        chk(o_aux_lcd_charge_en, 1'b0);
        chk(o_aux_trickle_en, 1'b0);
        results;
    end
endmodule
